// ==== logic/pilot_carrier_phase_recovery.v ====
`timescale 1ns/1ps
`include "pcr_map.vh"

module pcr_fifo #(
  parameter WIDTH = 48,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clk, // clock
  input wire resetn, // async reset
  input wire wr_valid, // write request
  output wire wr_ready, // room available
  input wire [WIDTH-1:0] wr_data, // write word
  output wire rd_valid, // word available
  input wire rd_ready, // reader takes word
  output wire [WIDTH-1:0] rd_data // head word
);
  localparam [AW:0] FULL = DEPTH;
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wp_reg;
  reg [AW:0] rp_reg;
  wire [AW:0] used = wp_reg - rp_reg;
  assign wr_ready = (used != FULL);
  assign rd_valid = (used != {(AW+1){1'b0}});
  assign rd_data = mem[rp_reg[AW-1:0]];
  always @(posedge clk) begin
    if (wr_valid && wr_ready) begin
      mem[wp_reg[AW-1:0]] <= wr_data;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wp_reg <= {(AW+1){1'b0}};
      rp_reg <= {(AW+1){1'b0}};
    end else begin
      if (wr_valid && wr_ready) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (rd_valid && rd_ready) begin
        rp_reg <= rp_reg + 1'b1;
      end
    end
  end
endmodule

module pilot_carrier_phase_recovery #(
  parameter SEG_DEPTH = `SEG_MAX,
  parameter FIFO_DEPTH = 32
) (
  input wire clk, // symbol clock
  input wire resetn, // async reset, active low
  input wire [1:0] mod_sel, // constellation of current frame
  input wire s_valid, // sample valid
  output wire s_ready, // sample accepted
  input wire s_pilot, // sample belongs to a pilot field
  input wire [15:0] s_i, // matched filter sample, real
  input wire [15:0] s_q, // matched filter sample, imag
  input wire [15:0] s_ref_i, // known pilot symbol, real
  input wire [15:0] s_ref_q, // known pilot symbol, imag
  output wire m_valid, // corrected symbol valid
  input wire m_ready, // demapper takes symbol
  output wire [15:0] m_i, // corrected symbol, real
  output wire [15:0] m_q, // corrected symbol, imag
  output wire [15:0] m_phase, // phase removed from symbol
  output wire est_valid, // one pulse per pilot field
  output wire [23:0] est_phase, // unwrapped pilot phase
  output wire [15:0] est_raw // wrapped pilot phase
);
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_VEC = 3'h1;
  localparam [2:0] S_UNW = 3'h2;
  localparam [2:0] S_SET = 3'h3;
  localparam [2:0] S_LDR = 3'h4;
  localparam [2:0] S_ROT = 3'h5;
  localparam [2:0] S_FIN = 3'h6;
  // ----------------------------------------
  // arctangent table, 2^16 per turn
  // ----------------------------------------
  function [15:0] atan_lut;
    input [3:0] i;
    begin
      case (i)
        4'h0: atan_lut = 16'h2000;
        4'h1: atan_lut = 16'h12E4;
        4'h2: atan_lut = 16'h09FB;
        4'h3: atan_lut = 16'h0511;
        4'h4: atan_lut = 16'h028B;
        4'h5: atan_lut = 16'h0146;
        4'h6: atan_lut = 16'h00A3;
        4'h7: atan_lut = 16'h0051;
        4'h8: atan_lut = 16'h0029;
        4'h9: atan_lut = 16'h0014;
        4'hA: atan_lut = 16'h000A;
        4'hB: atan_lut = 16'h0005;
        4'hC: atan_lut = 16'h0003;
        4'hD: atan_lut = 16'h0001;
        default: atan_lut = 16'h0001;
      endcase
    end
  endfunction

  reg [2:0] state_reg;
  reg [5:0] pcnt_reg;
  reg signed [39:0] acc_i_reg;
  reg signed [39:0] acc_q_reg;
  reg [10:0] wcnt_reg;
  reg [10:0] rcnt_reg;
  reg [31:0] seg_mem [0:SEG_DEPTH-1];
  reg signed [19:0] cx_reg;
  reg signed [19:0] cy_reg;
  reg [15:0] ca_reg;
  reg [3:0] ci_reg;
  reg cmode_reg;
  reg signed [23:0] unw_reg;
  reg signed [23:0] prev_reg;
  reg have_reg;
  reg signed [39:0] step_reg;
  reg signed [47:0] iacc_reg;
  reg signed [23:0] fine_reg;
  reg signed [23:0] integ_reg;
  reg est_valid_reg;
  reg [23:0] est_phase_reg;
  reg [15:0] est_raw_reg;
  wire f_ready;
  wire take = s_valid && (state_reg == S_IDLE);
  wire seg_room = (wcnt_reg < SEG_DEPTH);
  assign s_ready = (state_reg == S_IDLE);
  // ----------------------------------------
  // pilot correlation
  // ----------------------------------------
  wire signed [32:0] p_re = $signed(s_ref_i) * $signed(s_i) + $signed(s_ref_q) * $signed(s_q);
  wire signed [32:0] p_im = $signed(s_ref_i) * $signed(s_q) - $signed(s_ref_q) * $signed(s_i);
  wire signed [39:0] acc_i_next = acc_i_reg + p_re;
  wire signed [39:0] acc_q_next = acc_q_reg + p_im;
  wire signed [19:0] vx = {{2{acc_i_next[39]}}, acc_i_next[39:22]};
  wire signed [19:0] vy = {{2{acc_q_next[39]}}, acc_q_next[39:22]};

  // ----------------------------------------
  // shared cordic
  // ----------------------------------------
  wire signed [19:0] xs = cx_reg >>> ci_reg;
  wire signed [19:0] ys = cy_reg >>> ci_reg;
  wire cw = cmode_reg ? ~cy_reg[19] : ca_reg[15];
  wire [15:0] at = atan_lut(ci_reg);
  wire last_it = (ci_reg == `CORDIC_ITER - 4'h1);

  // ----------------------------------------
  // unwrap and slope
  // ----------------------------------------
  wire [15:0] dwrap = ca_reg - unw_reg[15:0];
  wire signed [23:0] dlt = $signed({{8{dwrap[15]}}, dwrap}) >>> `UNWRAP_SHIFT;
  wire signed [23:0] unw_next = unw_reg + dlt;
  wire signed [40:0] step_w = dlt * $signed({1'b0, `RECIP_SPACING});
  wire signed [47:0] iacc_init = $signed({prev_reg, 24'h000000})
                                 + step_reg * $signed({1'b0, `HALF_PILOT});

  // ----------------------------------------
  // fine phase detector
  // ----------------------------------------
  wire apsk = mod_sel[1];
  wire apsk32 = (mod_sel == `MOD_APSK32);
  wire [15:0] ang = iacc_reg[39:24] + fine_reg[23:8];
  wire [15:0] nang = 16'h0000 - ang;
  wire [31:0] rd_word = seg_mem[rcnt_reg];
  wire signed [7:0] fa = cx_reg[16:9];
  wire signed [7:0] fb = cy_reg[16:9];
  wire signed [15:0] fab = fa * fb;
  wire signed [16:0] z2r = fa * fa - fb * fb;
  wire signed [16:0] z2i = $signed({fab, 1'b0});
  wire signed [25:0] q3r = z2r * fa - z2i * fb;
  wire signed [25:0] q3i = z2r * fb + z2i * fa;
  wire signed [34:0] q4r = z2r * z2r - z2i * z2i;
  wire signed [33:0] z4p = z2r * z2i;
  wire signed [34:0] q4i = $signed({z4p, 1'b0});
  wire signed [35:0] qr = apsk32 ? q4r : (q3r <<< `Q3_ALIGN);
  wire signed [35:0] qi = apsk32 ? q4i : (q3i <<< `Q3_ALIGN);
  // quarter-pi turn done as add/sub; the common sqrt2 gain is irrelevant to slicing
  wire signed [36:0] br = apsk32 ? qr - qi : qr;
  wire signed [36:0] bi = apsk32 ? qr + qi : qi;
  wire signed [37:0] err = (br[36] ? -bi : bi) - (bi[36] ? -br : br);
  wire signed [37:0] esc = err >>> `ERR_SHIFT;
  wire signed [23:0] ef = esc[23:0];
  wire signed [23:0] integ_next = integ_reg + (ef >>> `KI_SHIFT);
  wire signed [23:0] fine_next = fine_reg + (ef >>> `KP_SHIFT) + integ_next;

  always @(posedge clk) begin
    if (take && !s_pilot && seg_room) begin
      seg_mem[wcnt_reg] <= {s_q, s_i};
    end
  end

  // ----------------------------------------
  // main sequencer
  // ----------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= S_IDLE;
      pcnt_reg <= 6'h00;
      acc_i_reg <= 40'sh0;
      acc_q_reg <= 40'sh0;
      wcnt_reg <= 11'h000;
      rcnt_reg <= 11'h000;
      cx_reg <= 20'sh0;
      cy_reg <= 20'sh0;
      ca_reg <= 16'h0000;
      ci_reg <= 4'h0;
      cmode_reg <= 1'b0;
      unw_reg <= 24'sh0;
      prev_reg <= 24'sh0;
      have_reg <= 1'b0;
      step_reg <= 40'sh0;
      iacc_reg <= 48'sh0;
      fine_reg <= 24'sh0;
      integ_reg <= 24'sh0;
      est_valid_reg <= 1'b0;
      est_phase_reg <= 24'h000000;
      est_raw_reg <= 16'h0000;
    end else begin
      est_valid_reg <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (take && s_pilot) begin
            if (pcnt_reg == `PILOT_LEN - 6'h01) begin
              // field complete: argument of the sum, no loop involved
              pcnt_reg <= 6'h00;
              acc_i_reg <= 40'sh0;
              acc_q_reg <= 40'sh0;
              cmode_reg <= 1'b1;
              ci_reg <= 4'h0;
              state_reg <= S_VEC;
              if (vx[19]) begin
                cx_reg <= -vx;
                cy_reg <= -vy;
                ca_reg <= `PI_ANGLE;
              end else begin
                cx_reg <= vx;
                cy_reg <= vy;
                ca_reg <= 16'h0000;
              end
            end else begin
              pcnt_reg <= pcnt_reg + 6'h01;
              acc_i_reg <= acc_i_next;
              acc_q_reg <= acc_q_next;
            end
          end else if (take && seg_room) begin
            wcnt_reg <= wcnt_reg + 11'h001;
          end
        end
        S_VEC, S_ROT: begin
          ci_reg <= ci_reg + 4'h1;
          if (cw) begin
            cx_reg <= cx_reg + ys;
            cy_reg <= cy_reg - xs;
            ca_reg <= ca_reg + at;
          end else begin
            cx_reg <= cx_reg - ys;
            cy_reg <= cy_reg + xs;
            ca_reg <= ca_reg - at;
          end
          if (last_it) begin
            state_reg <= (state_reg == S_VEC) ? S_UNW : S_FIN;
          end
        end
        S_UNW: begin
          est_valid_reg <= 1'b1;
          est_raw_reg <= ca_reg;
          prev_reg <= unw_reg;
          have_reg <= 1'b1;
          step_reg <= step_w[39:0];
          if (have_reg) begin
            unw_reg <= unw_next;
            est_phase_reg <= unw_next;
          end else begin
            unw_reg <= $signed({{8{ca_reg[15]}}, ca_reg});
            est_phase_reg <= {{8{ca_reg[15]}}, ca_reg};
          end
          if (have_reg && wcnt_reg != 11'h000) begin
            state_reg <= S_SET;
          end else begin
            // data ahead of the first pilot has no bracket and is dropped
            wcnt_reg <= 11'h000;
            state_reg <= S_IDLE;
          end
        end
        S_SET: begin
          iacc_reg <= iacc_init;
          rcnt_reg <= 11'h000;
          state_reg <= S_LDR;
        end
        S_LDR: begin
          // pilot trajectory and fine phase are removed in one rotation
          cmode_reg <= 1'b0;
          ci_reg <= 4'h0;
          state_reg <= S_ROT;
          if (nang[15] ^ nang[14]) begin
            cx_reg <= -$signed({{4{rd_word[15]}}, rd_word[15:0]});
            cy_reg <= -$signed({{4{rd_word[31]}}, rd_word[31:16]});
            ca_reg <= nang + `PI_ANGLE;
          end else begin
            cx_reg <= $signed({{4{rd_word[15]}}, rd_word[15:0]});
            cy_reg <= $signed({{4{rd_word[31]}}, rd_word[31:16]});
            ca_reg <= nang;
          end
        end
        S_FIN: begin
          if (f_ready) begin
            iacc_reg <= iacc_reg + step_reg;
            if (apsk) begin
              integ_reg <= integ_next;
              fine_reg <= fine_next;
            end else begin
              integ_reg <= 24'sh0;
              fine_reg <= 24'sh0;
            end
            if (rcnt_reg == wcnt_reg - 11'h001) begin
              wcnt_reg <= 11'h000;
              state_reg <= S_IDLE;
            end else begin
              rcnt_reg <= rcnt_reg + 11'h001;
              state_reg <= S_LDR;
            end
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  assign est_valid = est_valid_reg;
  assign est_phase = est_phase_reg;
  assign est_raw = est_raw_reg;
  // ----------------------------------------
  // output buffer
  // ----------------------------------------
  // a stalled demapper fills this and then holds the sequencer in S_FIN
  pcr_fifo #(
    .WIDTH(48),
    .DEPTH(FIFO_DEPTH),
    .AW(5)
  ) u_out_fifo (
    .clk(clk),
    .resetn(resetn),
    .wr_valid(state_reg == S_FIN),
    .wr_ready(f_ready),
    .wr_data({ang, cy_reg[16:1], cx_reg[16:1]}),
    .rd_valid(m_valid),
    .rd_ready(m_ready),
    .rd_data({m_phase, m_q, m_i})
  );
endmodule

// ==== logic/pcr_map.vh ====
`ifndef PCR_MAP_VH
`define PCR_MAP_VH
// ----------------------------------------
// frame geometry
// ----------------------------------------
`define PILOT_LEN 6'h24
`define PILOT_SPACING 11'h5C4
`define SEG_MAX 1440
`define HALF_PILOT 7'h12
// 2^24 / pilot spacing, so delta * this is a per-symbol slope in 24-bit fraction
`define RECIP_SPACING 16'h2C66
// unwrap gain is 2^-shift; shift 0 gives gain one
`define UNWRAP_SHIFT 0
// ----------------------------------------
// cordic and phase format (2^16 = one turn)
// ----------------------------------------
`define CORDIC_ITER 4'hE
`define PI_ANGLE 16'h8000
// ----------------------------------------
// modulation select
// ----------------------------------------
`define MOD_QPSK 2'h0
`define MOD_8PSK 2'h1
`define MOD_APSK16 2'h2
`define MOD_APSK32 2'h3
// ----------------------------------------
// fine loop scaling
// ----------------------------------------
`define Q3_ALIGN 7
`define ERR_SHIFT 14
`define KP_SHIFT 2
`define KI_SHIFT 8
`endif

// ==== tb/pcr_monitor.sv ====
`timescale 1ns/1ps
module pcr_monitor (
  input wire clk, // clock
  input wire resetn, // reset
  input wire s_valid, // in valid
  input wire s_ready, // in ready
  input wire s_pilot, // pilot flag
  input wire m_valid, // out valid
  input wire m_ready, // out ready
  input wire [15:0] m_i, // out re
  input wire [15:0] m_q, // out im
  input wire [15:0] m_phase, // out phase
  input wire est_valid, // estimate
  input wire [23:0] est_phase, // unwrapped
  input wire [15:0] est_raw // wrapped
);
  reg [5:0] pcnt_reg;
  reg [23:0] prev_reg;
  wire take = s_valid && s_ready && s_pilot;
  wire last = take && pcnt_reg == 6'h23;
  wire signed [23:0] step = est_phase - prev_reg;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pcnt_reg <= 6'h00;
      prev_reg <= 24'h000000;
    end else begin
      if (take)
        pcnt_reg <= last ? 6'h00 : pcnt_reg + 6'h01;
      if (est_valid)
        prev_reg <= est_phase;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_end; last; endsequence
  sequence s_est; ##16 est_valid ##1 !est_valid; endsequence
  property p_lat; s_end |-> s_est; endproperty
  a_lat: assert property (p_lat) else $error("estimate timing wrong");
  property p_one; est_valid |-> $past(last, 16); endproperty
  a_one: assert property (p_one) else $error("estimate without field");
  property p_pulse; est_valid |=> !est_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("estimate too long");
  property p_busy; s_end |=> !s_ready [*8]; endproperty
  a_busy: assert property (p_busy) else $error("input taken while estimating");
  property p_hold; $rose(m_valid) |-> !$past(s_ready); endproperty
  a_hold: assert property (p_hold) else $error("output word outside a drain");
  property p_stall; m_valid && !m_ready |=> m_valid && $stable({m_i, m_q, m_phase}); endproperty
  a_stall: assert property (p_stall) else $error("output word moved");
  property p_wrap; est_valid |-> est_phase[15:0] == est_raw; endproperty
  a_wrap: assert property (p_wrap) else $error("unwrap gain not one");
  property p_step; est_valid |-> step >= -24'sd32768 && step < 24'sd32768; endproperty
  a_step: assert property (p_step) else $error("unwrap step too big");
endmodule

// ==== tb/pcr_sink.sv ====
`timescale 1ns/1ps
module pcr_sink (
  input wire clk, // clock
  input wire resetn, // reset
  input wire stall, // refuse words
  input wire slow, // every other cycle
  input wire m_valid, // word offered
  output reg m_ready, // word taken
  input wire [15:0] m_i, // word real
  input wire [15:0] m_q, // word imag
  input wire [15:0] m_phase // word phase
);
  reg [47:0] log_mem [0:63];
  reg [31:0] count;
  reg tick;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      m_ready <= 1'b0;
      count <= 32'h00000000;
      tick <= 1'b0;
    end else begin
      tick <= ~tick;
      m_ready <= !stall && (!slow || tick);
      if (m_valid && m_ready) begin
        log_mem[count[5:0]] <= {m_q, m_i, m_phase};
        count <= count + 32'h00000001;
      end
    end
  end
endmodule

// ==== tb/pilot_carrier_phase_recovery_tb.sv ====
`timescale 1ns/1ps
module pilot_carrier_phase_recovery_tb;
  reg clk, resetn, s_valid, s_pilot, stall, slow;
  reg [1:0] mod_sel;
  reg [15:0] s_i, s_q, s_ref_i, s_ref_q;
  reg alt;
  reg [47:0] obs;
  wire s_ready, m_valid, m_ready, est_valid;
  wire [15:0] m_i, m_q, m_phase, est_raw;
  wire [23:0] est_phase;
  integer n_mismatch = 0;
  integer total_checks = 0;
  integer cycles = 0;
  integer base, k, m;
  pilot_carrier_phase_recovery u_pilot_carrier_phase_recovery (
    .clk(clk), .resetn(resetn), .mod_sel(mod_sel), .s_valid(s_valid), .s_ready(s_ready),
    .s_pilot(s_pilot), .s_i(s_i), .s_q(s_q), .s_ref_i(s_ref_i), .s_ref_q(s_ref_q),
    .m_valid(m_valid), .m_ready(m_ready), .m_i(m_i), .m_q(m_q), .m_phase(m_phase),
    .est_valid(est_valid), .est_phase(est_phase), .est_raw(est_raw));
  pcr_sink u_pcr_sink (.clk(clk), .resetn(resetn), .stall(stall), .slow(slow),
    .m_valid(m_valid), .m_ready(m_ready), .m_i(m_i), .m_q(m_q), .m_phase(m_phase));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      n_mismatch = n_mismatch + 1;
      conclude;
    end
  end
  task conclude;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task check(input [63:0] name, input [23:0] seen, input [23:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED %0s expected %h seen %h", name, exp, seen);
    end
  endtask
  // cordic and truncation leave a few counts of error
  function [23:0] near(input [23:0] d);
    near = ($signed(d) > -24'sd64 && $signed(d) < 24'sd64) ? 24'h000001 : 24'h000000;
  endfunction
  function [23:0] near16(input [15:0] d);
    near16 = near({{8{d[15]}}, d});
  endfunction
  // point at quad times a quarter turn, {re, im}
  function [31:0] pt(input [1:0] quad);
    case (quad)
      2'h0: pt = {16'h4000, 16'h0000};
      2'h1: pt = {16'h0000, 16'h4000};
      2'h2: pt = {16'hC000, 16'h0000};
      default: pt = {16'h0000, 16'hC000};
    endcase
  endfunction
  task put(input p, input [31:0] iq);
    s_valid <= 1'b1;
    s_pilot <= p;
    s_i <= iq[31:16];
    s_q <= iq[15:0];
    s_ref_i <= (p && !alt) ? 16'h4000 : 16'h0000;
    s_ref_q <= (p && alt) ? 16'h4000 : 16'h0000;
    @(posedge clk);
    while (s_ready !== 1'b1)
      @(posedge clk);
  endtask
  task pilot(input [1:0] quad, input [23:0] exp);
    integer j;
    // odd samples use a quarter-turn reference so both conjugate terms are exercised
    for (j = 0; j < 36; j = j + 1) begin
      alt = j[0];
      put(1'b1, pt(quad + {1'b0, alt}));
    end
    s_valid <= 1'b0;
    for (j = 0; j < 40 && est_valid !== 1'b1; j = j + 1)
      @(posedge clk);
    check("estflag", {23'h000000, est_valid}, 24'h000001);
    check("raw", near16(est_raw - {quad, 14'h0000}), 24'h000001);
    check("unwrap", near(est_phase - exp), 24'h000001);
  endtask
  task wait_words(input integer n);
    integer j;
    for (j = 0; j < 3000 && u_pcr_sink.count < n; j = j + 1)
      @(posedge clk);
    check("words", u_pcr_sink.count[23:0], n[23:0]);
  endtask
  task seg(input integer n, input [15:0] p0, input integer slope);
    integer j;
    reg [15:0] e;
    for (j = 0; j < n; j = j + 1) begin
      e = p0 + (slope * (18 + j)) / 1476;
      obs = u_pcr_sink.log_mem[(base + j) % 64];
      check("phase", near16(obs[15:0] - e), 24'h000001);
    end
  endtask
  initial begin
    resetn = 1'b0;
    s_valid = 1'b0;
    s_pilot = 1'b0;
    stall = 1'b0;
    slow = 1'b0;
    mod_sel = 2'h0;
    s_i = 16'h0000;
    s_q = 16'h0000;
    s_ref_i = 16'h0000;
    s_ref_q = 16'h0000;
    alt = 1'b0;
    repeat (8) @(posedge clk);
    check("rst_est", {23'h000000, est_valid}, 24'h000000);
    check("rst_out", {23'h000000, m_valid}, 24'h000000);
    check("rst_ph", est_phase, 24'h000000);
    resetn <= 1'b1;
    @(posedge clk);
    $display("test reset done");
    // no left estimate yet, so these are dropped
    for (k = 0; k < 3; k = k + 1)
      put(1'b0, pt(2'h1));
    pilot(2'h0, 24'h000000);
    pilot(2'h1, 24'h004000);
    pilot(2'h2, 24'h008000);
    pilot(2'h3, 24'h00C000);
    pilot(2'h0, 24'h010000);
    repeat (40) @(posedge clk);
    check("dropped", u_pcr_sink.count[23:0], 24'h000000);
    $display("test unwrap done");
    base = u_pcr_sink.count;
    for (k = 0; k < 8; k = k + 1)
      put(1'b0, pt(2'h1));
    pilot(2'h1, 24'h014000);
    wait_words(base + 8);
    seg(8, 16'h0000, 16384);
    $display("test interpolation done");
    stall <= 1'b1;
    mod_sel <= 2'h1;
    base = u_pcr_sink.count;
    for (k = 0; k < 40; k = k + 1)
      put(1'b0, pt(2'h1));
    pilot(2'h1, 24'h014000);
    repeat (700) @(posedge clk);
    check("full", {23'h000000, s_ready}, 24'h000000);
    check("held", u_pcr_sink.count[23:0], base[23:0]);
    stall <= 1'b0;
    slow <= 1'b1;
    wait_words(base + 40);
    seg(40, 16'h4000, 0);
    // cordic gain over two scales a 4000 input to about 34B2
    for (k = 0; k < 40; k = k + 1) begin
      obs = u_pcr_sink.log_mem[(base + k) % 64];
      check("out_i", near16(obs[31:16] - 16'h34B2), 24'h000001);
      check("out_q", near16(obs[47:32]), 24'h000001);
    end
    $display("test buffer done");
    slow <= 1'b0;
    // each point sits on its powered detector's lock angle: 15 deg cubed, 0 deg to the fourth
    for (m = 2; m < 4; m = m + 1) begin
      mod_sel <= m[1:0];
      base = u_pcr_sink.count;
      for (k = 0; k < 4; k = k + 1)
        put(1'b0, (m == 2) ? 32'hEF703DD2 : pt(2'h1));
      pilot(2'h1, 24'h014000);
      wait_words(base + 4);
      seg(4, 16'h4000, 0);
    end
    $display("test apsk done");
    conclude;
  end
endmodule
bind pilot_carrier_phase_recovery pcr_monitor u_pcr_monitor (.clk(clk), .resetn(resetn),
  .s_valid(s_valid), .s_ready(s_ready), .s_pilot(s_pilot), .m_valid(m_valid),
  .m_ready(m_ready), .m_i(m_i), .m_q(m_q), .m_phase(m_phase), .est_valid(est_valid),
  .est_phase(est_phase), .est_raw(est_raw));
